// *** include/dsw_pkg.sv ***
package dsw_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int DQ_W    = 36;
   localparam int ADDR_W  = 4;
   localparam int LANE_W  = 9;
   localparam int NIB_W   = 4;
   localparam int LANES   = 4;
   localparam int FIFO_D  = 32;
   localparam int CNT_W   = 16;
   localparam int WB_AW   = 8;

   // ----------------------------------------
   // link timing, in link clock cycles
   // ----------------------------------------
   localparam int RD_LAT   = 2;
   localparam int TURN_LAT = 2;

   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_WR_CNT    = 8'h08;
   localparam logic [7:0] REG_ABORT_CNT = 8'h0c;
   localparam logic [7:0] REG_DROP_CNT  = 8'h10;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int         CTRL_MODE_LSB = 0;
   localparam int         CTRL_HOLD_BIT = 2;
   localparam logic [1:0] MODE_RESET    = 2'h0;
   localparam logic       HOLD_RESET    = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam int         ST_TERM_BIT   = 0;
   localparam int         ST_FULL_BIT   = 1;
   localparam int         ST_EMPTY_BIT  = 2;
   localparam int         ST_DRIVE_BIT  = 3;
   localparam int         ST_WST_LSB    = 4;

   // ----------------------------------------
   // modes, commands, states
   // ----------------------------------------
   localparam logic [1:0] MODE_X36 = 2'h0;
   localparam logic [1:0] MODE_X18 = 2'h1;
   localparam logic [1:0] MODE_X8  = 2'h2;

   typedef enum logic [1:0] {
      CMD_NOP   = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_READ  = 2'h2
   } dsw_cmd_t;

   typedef enum logic [2:0] {
      W_IDLE  = 3'b001,
      W_BEAT1 = 3'b010,
      W_BEAT2 = 3'b100
   } dsw_wstate_t;

endpackage

// *** logic/dsw_sram.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// write fifo
// ----------------------------------------
module dsw_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic             push;
   logic             pop;

   // handshake terms
   assign in_ready  = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = store[rd_ptr];

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // dsw_fifo

// ----------------------------------------
// sram command and write mask core
// ----------------------------------------
module dsw_sram
   import dsw_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              link_k,
   input  wire logic              link_k_n,
   input  wire logic              load_strobe_n,
   input  wire logic              rw_select,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [3:0]        lane_write_mask_n,
   input  wire logic [1:0]        nibble_write_mask_n,
   input  wire logic              termination_select,
   input  wire logic [DQ_W-1:0]   dq_in,
   output logic [DQ_W-1:0]        dq_out,
   output logic [DQ_W-1:0]        dq_oe_n,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [WB_AW-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o
);
   localparam int PIN_W = 2 + 1 + 1 + ADDR_W + 4 + 2 + 1 + DQ_W;
   localparam int ENT_W = ADDR_W + 4*DQ_W;

   // ----------------------------------------
   // lane mask expansion
   // ----------------------------------------
   function automatic logic [DQ_W-1:0] mask_expand(
      input logic [1:0] mode,
      input logic [3:0] lane_n,
      input logic [1:0] nib_n
   );
      logic [DQ_W-1:0] en;
      en = '0;
      if (mode == MODE_X8) begin
         en[NIB_W-1:0]       = {NIB_W{~nib_n[0]}};
         en[2*NIB_W-1:NIB_W] = {NIB_W{~nib_n[1]}};
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (mode != MODE_X18 || i < 2) begin
               en[i*LANE_W +: LANE_W] = {LANE_W{~lane_n[i]}};
            end
         end
      end
      return en;
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [PIN_W-1:0]  pin_meta;
   logic [PIN_W-1:0]  pin_sync;
   logic              k_prev;
   logic              kn_prev;
   logic              s_k;
   logic              s_kn;
   logic              s_strobe_n;
   logic              s_rw;
   logic [ADDR_W-1:0] s_addr;
   logic [3:0]        s_lane_n;
   logic [1:0]        s_nib_n;
   logic              s_term;
   logic [DQ_W-1:0]   s_dq;
   logic              k_rise;
   logic              kn_rise;

   // two flops on every pin
   always_ff @(posedge clk) begin
      pin_meta <= {link_k, link_k_n, load_strobe_n, rw_select, addr,
                   lane_write_mask_n, nibble_write_mask_n,
                   termination_select, dq_in};
      pin_sync <= pin_meta;
   end

   assign {s_k, s_kn, s_strobe_n, s_rw, s_addr, s_lane_n, s_nib_n,
           s_term, s_dq} = pin_sync;

   // link clock edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         k_prev  <= 1'b0;
         kn_prev <= 1'b1; // idle level of the complementary pin
      end else begin
         k_prev  <= s_k;
         kn_prev <= s_kn;
      end
   end

   assign k_rise  = s_k & ~k_prev;
   assign kn_rise = s_kn & ~kn_prev;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic [1:0]       width_mode;
   logic             drain_hold;
   logic [CNT_W-1:0] wr_cnt;
   logic [CNT_W-1:0] abort_cnt;
   logic [CNT_W-1:0] drop_cnt;
   logic             wb_req;
   logic             fifo_full;
   logic             fifo_empty;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // ctrl register write
   always_ff @(posedge clk) begin
      if (rst) begin
         width_mode <= MODE_RESET;
         drain_hold <= HOLD_RESET;
      end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == REG_CTRL) begin
            width_mode <= wb_dat_i[CTRL_MODE_LSB +: 2];
            drain_hold <= wb_dat_i[CTRL_HOLD_BIT];
         end
      end
   end

   // ----------------------------------------
   // command decode and read pipeline
   // ----------------------------------------
   dsw_cmd_t          cmd_pipe  [RD_LAT];
   logic [ADDR_W-1:0] addr_pipe [RD_LAT];
   dsw_cmd_t          cmd_now;

   always_comb begin
      if (s_strobe_n) begin
         cmd_now = CMD_NOP;
      end else if (s_rw) begin
         cmd_now = CMD_READ;
      end else begin
         cmd_now = CMD_WRITE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < RD_LAT; i++) begin
            cmd_pipe[i]  <= CMD_NOP;
            addr_pipe[i] <= '0;
         end
      end else if (k_rise) begin
         cmd_pipe[0]  <= cmd_now;
         addr_pipe[0] <= s_addr;
         for (int i = 1; i < RD_LAT; i++) begin
            cmd_pipe[i]  <= cmd_pipe[i-1];
            addr_pipe[i] <= addr_pipe[i-1];
         end
      end
   end

   // ----------------------------------------
   // write beat capture
   // ----------------------------------------
   dsw_wstate_t       wstate;
   logic [ADDR_W-1:0] w_addr;
   logic [ADDR_W-1:0] pend_addr;
   logic              pend;
   logic [DQ_W-1:0]   beat1_d;
   logic [DQ_W-1:0]   beat1_e;
   logic [DQ_W-1:0]   beat2_e;
   logic              push_valid;
   logic              push_ready;
   logic [ENT_W-1:0]  push_data;
   logic              burst_done;

   assign beat2_e    = mask_expand(width_mode, s_lane_n, s_nib_n);
   assign burst_done = (wstate == W_BEAT2) && kn_rise;
   assign push_valid = burst_done && (beat1_e != '0 || beat2_e != '0);
   // entry holds base beat then next beat
   assign push_data  = {w_addr, beat1_d, beat1_e, s_dq, beat2_e};

   // capture state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         wstate    <= W_IDLE;
         w_addr    <= '0;
         pend_addr <= '0;
         pend      <= 1'b0;
         beat1_d   <= '0;
         beat1_e   <= '0;
      end else begin
         case (wstate)
            W_IDLE: begin
               if (k_rise && cmd_now == CMD_WRITE) begin
                  w_addr <= s_addr;
                  wstate <= W_BEAT1;
               end
            end
            W_BEAT1: begin
               // first beat on next true edge
               if (k_rise) begin
                  beat1_d <= s_dq;
                  beat1_e <= mask_expand(width_mode, s_lane_n, s_nib_n);
                  pend      <= (cmd_now == CMD_WRITE);
                  pend_addr <= s_addr;
                  wstate    <= W_BEAT2;
               end
            end
            W_BEAT2: begin
               // second beat half a cycle later
               if (kn_rise) begin
                  pend <= 1'b0;
                  if (pend) begin
                     w_addr <= pend_addr;
                     wstate <= W_BEAT1;
                  end else begin
                     wstate <= W_IDLE;
                  end
               end
            end
            default: begin
               wstate <= W_IDLE;
            end
         endcase
      end
   end

   logic              drain_valid;
   logic              drain_ready;
   logic [ENT_W-1:0]  drain_data;

   // write fifo between link and array
   dsw_fifo #(
      .WIDTH (ENT_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   // ----------------------------------------
   // memory array
   // ----------------------------------------
   logic [DQ_W-1:0]   mem_b0 [2**ADDR_W];
   logic [DQ_W-1:0]   mem_b1 [2**ADDR_W];
   logic [ADDR_W-1:0] d_addr;
   logic [DQ_W-1:0]   d_d1;
   logic [DQ_W-1:0]   d_e1;
   logic [DQ_W-1:0]   d_d2;
   logic [DQ_W-1:0]   d_e2;
   logic              drain;

   assign fifo_full   = ~push_ready;
   assign fifo_empty  = ~drain_valid;
   assign drain_ready = ~drain_hold;
   assign drain       = drain_valid & drain_ready;
   assign {d_addr, d_d1, d_e1, d_d2, d_e2} = drain_data;

   // each beat uses its own enables
   always_ff @(posedge clk) begin
      if (drain) begin
         mem_b0[d_addr] <= (mem_b0[d_addr] & ~d_e1) | (d_d1 & d_e1);
         mem_b1[d_addr] <= (mem_b1[d_addr] & ~d_e2) | (d_d2 & d_e2);
      end
   end

   // ----------------------------------------
   // event counters
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_cnt    <= CNT_RESET;
         abort_cnt <= CNT_RESET;
         drop_cnt  <= CNT_RESET;
      end else begin
         if (drain) begin
            wr_cnt <= wr_cnt + 1'b1;
         end
         // no enabled lane or nibble in either beat
         if (burst_done && beat1_e == '0 && beat2_e == '0) begin
            abort_cnt <= abort_cnt + 1'b1;
         end
         if (push_valid && !push_ready) begin
            drop_cnt <= drop_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read data drivers
   // ----------------------------------------
   logic [DQ_W-1:0] q_second;
   logic            driving;
   logic            rd_due;

   assign rd_due = (cmd_pipe[RD_LAT-1] == CMD_READ);

   // output drivers and turnaround
   always_ff @(posedge clk) begin
      if (rst) begin
         dq_out   <= '0;
         dq_oe_n  <= '1;
         q_second <= '0;
         driving  <= 1'b0;
      end else if (k_rise) begin
         if (rd_due) begin
            dq_out   <= mem_b0[addr_pipe[RD_LAT-1]];
            q_second <= mem_b1[addr_pipe[RD_LAT-1]];
            dq_oe_n  <= '0;
            driving  <= 1'b1;
         end else begin
            // drivers off after nop or write
            dq_oe_n <= '1;
            driving <= 1'b0;
         end
      end else if (kn_rise && driving) begin
         dq_out <= q_second;
      end
   end

   // ----------------------------------------
   // wishbone read and ack
   // ----------------------------------------
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (wb_adr_i == REG_CTRL) begin
         rd_word[CTRL_MODE_LSB +: 2] = width_mode;
         rd_word[CTRL_HOLD_BIT]      = drain_hold;
      end else if (wb_adr_i == REG_STATUS) begin
         rd_word[ST_TERM_BIT]      = s_term;
         rd_word[ST_FULL_BIT]      = fifo_full;
         rd_word[ST_EMPTY_BIT]     = fifo_empty;
         rd_word[ST_DRIVE_BIT]     = driving;
         rd_word[ST_WST_LSB +: 3]  = wstate;
      end else if (wb_adr_i == REG_WR_CNT) begin
         rd_word[CNT_W-1:0] = wr_cnt;
      end else if (wb_adr_i == REG_ABORT_CNT) begin
         rd_word[CNT_W-1:0] = abort_cnt;
      end else if (wb_adr_i == REG_DROP_CNT) begin
         rd_word[CNT_W-1:0] = drop_cnt;
      end
   end

   // one wait state, unmapped reads give zero
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_word;
         end
      end
   end
endmodule // dsw_sram

// *** dv/dsw_sram_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module dsw_sram_asserts
   import dsw_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            link_k,
   input wire logic            load_strobe_n,
   input wire logic            rw_select,
   input wire logic [DQ_W-1:0] dq_out,
   input wire logic [DQ_W-1:0] dq_oe_n,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic [31:0]     wb_dat_o,
   input wire logic            wb_ack_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic       k_q;
   logic [7:0] rd_age;

   // cycles since the last read command seen at the pins
   always_ff @(posedge clk) begin
      k_q <= link_k;
      if (rst)
         rd_age <= 8'hff;
      else if (link_k && !k_q && !load_strobe_n && rw_select)
         rd_age <= 8'h00;
      else if (rd_age != 8'hff)
         rd_age <= rd_age + 8'h01;
   end

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved without ack");
   chk_oe_uniform: assert property (dq_oe_n == '0 || dq_oe_n == '1)
      else $error("data enables disagree");
   chk_idle_after_rst: assert property ($fell(rst) |-> (&dq_oe_n) && !wb_ack_o)
      else $error("outputs active out of reset");
   chk_drive_window: assert property (!dq_oe_n[0] |-> rd_age >= 8'h0f && rd_age <= 8'h1c)
      else $error("data driven outside read slot");
   chk_beat_hold: assert property ($fell(dq_oe_n[0]) |=> $stable(dq_out) [*2])
      else $error("first read beat not held");
endmodule // dsw_sram_asserts

bind dsw_sram dsw_sram_asserts u_chk (.clk(clk), .rst(rst), .link_k(link_k), .load_strobe_n(load_strobe_n),
   .rw_select(rw_select), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// *** dv/dsw_ctl_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// memory controller model
// ----------------------------------------
module dsw_ctl_model
   import dsw_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DQ_W-1:0]   dq_out,
   input  wire logic [DQ_W-1:0]   dq_oe_n,
   output logic                   link_k,
   output logic                   link_k_n,
   output logic                   load_strobe_n,
   output logic                   rw_select,
   output logic [ADDR_W-1:0]      addr,
   output logic [3:0]             lane_write_mask_n,
   output logic [1:0]             nibble_write_mask_n,
   output logic [DQ_W-1:0]        dq_drv
);
   logic            p_wr;
   logic [3:0]      pl1, pl2;
   logic [1:0]      pn1, pn2;
   logic [DQ_W-1:0] pd1, pd2;
   logic            s_oe_k, s_oe_kn;
   logic [DQ_W-1:0] s_dq_k, s_dq_kn;

   // idle pins, link clock parked
   initial begin
      link_k = 1'b0;
      link_k_n = 1'b1;
      load_strobe_n = 1'b1;
      rw_select = 1'b0;
      addr = '0;
      lane_write_mask_n = 4'hf;
      nibble_write_mask_n = 2'h3;
      dq_drv = '0;
      p_wr = 1'b0;
   end

   // one half link cycle: pins set two clocks before the edge, sampled at it
   task automatic half(input logic kv, strb, rw, input logic [ADDR_W-1:0] a, input logic [3:0] l,
                       input logic [1:0] n, input logic [DQ_W-1:0] d, output logic so, output logic [DQ_W-1:0] sd);
      @(posedge clk);
      load_strobe_n <= strb;
      rw_select <= rw;
      addr <= a;
      lane_write_mask_n <= l;
      nibble_write_mask_n <= n;
      dq_drv <= d;
      repeat (2) @(posedge clk);
      link_k <= kv;
      link_k_n <= !kv;
      #1;
      so = dq_oe_n[0];
      sd = dq_out;
      @(posedge clk);
   endtask

   // one link cycle: command on k rise, pending write beats follow
   task automatic kcyc(input logic strb, rw, input logic [ADDR_W-1:0] a, input logic [3:0] l1, l2,
                       input logic [1:0] n1, n2, input logic [DQ_W-1:0] d1, d2);
      // first beat with next edge, masks high when idle
      half(1'b1, strb, rw, a, p_wr ? pl1 : 4'hf, p_wr ? pn1 : 2'h3, p_wr ? pd1 : ~dq_drv, s_oe_k, s_dq_k);
      // second beat; lookalike read on the pins here
      half(1'b0, 1'b0, 1'b1, ~a, p_wr ? pl2 : 4'hf, p_wr ? pn2 : 2'h3, p_wr ? pd2 : ~dq_drv, s_oe_kn, s_dq_kn);
      p_wr = !strb && !rw;
      pl1 = l1;
      pl2 = l2;
      pn1 = n1;
      pn2 = n2;
      pd1 = d1;
      pd2 = d2;
   endtask
endmodule // dsw_ctl_model

// *** dv/test_ddr_sram_b2_command_write_mask.sv ***
`timescale 1ns/1ps
module test_ddr_sram_b2_command_write_mask
   import dsw_pkg::*;
;
   logic clk, rst, link_k, link_k_n, load_strobe_n, rw_select, termination_select;
   logic [ADDR_W-1:0] addr;
   logic [3:0] lane_write_mask_n, wb_sel;
   logic [1:0] nibble_write_mask_n, mode;
   logic [DQ_W-1:0] dq_in, dq_out, dq_oe_n, dq_drv;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [31:0] wb_dat, wb_q, q;
   logic [DQ_W-1:0] mem0 [16];
   logic [DQ_W-1:0] mem1 [16];
   int n_mismatch, tests_run;

   // data wire: device wins while its enable is low
   assign dq_in = (dq_out & ~dq_oe_n) | (dq_drv & dq_oe_n);

   dsw_sram u_dut (.clk(clk), .rst(rst), .link_k(link_k), .link_k_n(link_k_n), .load_strobe_n(load_strobe_n),
      .rw_select(rw_select), .addr(addr), .lane_write_mask_n(lane_write_mask_n),
      .nibble_write_mask_n(nibble_write_mask_n), .termination_select(termination_select), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
   dsw_ctl_model u_ctl (.clk(clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .link_k(link_k), .link_k_n(link_k_n),
      .load_strobe_n(load_strobe_n), .rw_select(rw_select), .addr(addr), .lane_write_mask_n(lane_write_mask_n),
      .nibble_write_mask_n(nibble_write_mask_n), .dq_drv(dq_drv));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [DQ_W-1:0] e, input logic [DQ_W-1:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n == 50) n_mismatch++;
      q = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      wb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), 36'(e & m), 36'(q & m));
   endtask

   // ----------------------------------------
   // link operations and array model
   // ----------------------------------------
   function automatic logic [DQ_W-1:0] smask(input logic [3:0] l, input logic [1:0] n);
      logic [DQ_W-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++)
         if (!l[i] && (mode == MODE_X36 || (mode == MODE_X18 && i < 2))) m[i*LANE_W +: LANE_W] = '1;
      for (int i = 0; i < 2; i++)
         if (!n[i] && mode == MODE_X8) m[i*NIB_W +: NIB_W] = '1;
      return m;
   endfunction

   function automatic logic [DQ_W-1:0] pat(input int i);
      return {i[3:0], 32'h9e3779b9 * i[31:0]};
   endfunction

   task automatic nop();
      u_ctl.kcyc(1'b1, 1'b1, '0, 4'hf, 4'hf, 2'h3, 2'h3, '0, '0);
   endtask

   task automatic wr(input int a, input logic [3:0] l1, input logic [1:0] n1, input logic [DQ_W-1:0] d1,
                     input logic [3:0] l2, input logic [1:0] n2, input logic [DQ_W-1:0] d2);
      u_ctl.kcyc(1'b0, 1'b0, 4'(a), l1, l2, n1, n2, d1, d2);
      nop();
      nop();
      mem0[a] = (mem0[a] & ~smask(l1, n1)) | (d1 & smask(l1, n1));
      mem1[a] = (mem1[a] & ~smask(l2, n2)) | (d2 & smask(l2, n2));
   endtask

   task automatic rd(input int a);
      logic [DQ_W-1:0] cm;
      cm = (mode == MODE_X36) ? '1 : (mode == MODE_X18) ? 36'h00003ffff : 36'h0000000ff;
      u_ctl.kcyc(1'b0, 1'b1, 4'(a), 4'hf, 4'hf, 2'h3, 2'h3, '0, '0);
      nop();
      nop();
      chk("beat1 enable", '0, 36'(u_ctl.s_oe_kn));
      chk("beat1 data", mem0[a] & cm, u_ctl.s_dq_kn & cm);
      nop();
      chk("beat2 enable", '0, 36'(u_ctl.s_oe_k));
      chk("beat2 data", mem1[a] & cm, u_ctl.s_dq_k & cm);
      chk("float after read", 36'h1, 36'(u_ctl.s_oe_kn));
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      wb_sel = 4'hf;
      termination_select = 1'b0;
      mode = MODE_X36;
      n_mismatch = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdr(REG_CTRL, {29'h0, HOLD_RESET, MODE_RESET}, 32'h7);
      rdr(REG_STATUS, 32'h4, 32'hf);
      wb(1'b1, REG_STATUS, 32'hffff_ffff);
      rdr(REG_STATUS, 32'h4, 32'hf);
      wb(1'b1, 8'h20, 32'hffff_ffff);
      rdr(8'h20, 32'h0, 32'hffff_ffff);
      for (int i = 0; i < 3; i++) rdr(REG_WR_CNT + 8'(4 * i), 32'(CNT_RESET), 32'hffff);
      for (int p = 0; p < 16; p++) begin
         wr(p, 4'h0, 2'h3, pat(p), 4'h0, 2'h3, pat(p + 16));
         wr(p, 4'(p), 2'h3, pat(p + 32), ~4'(p), 2'h3, pat(p + 48));
         rd(p);
      end
      rdr(REG_WR_CNT, 32'h20, 32'hffff);
      wr(5, 4'hf, 2'h3, pat(70), 4'hf, 2'h3, pat(71));
      rd(5);
      rdr(REG_ABORT_CNT, 32'h1, 32'hffff);
      termination_select <= 1'b1;
      // let the pin pass both synchroniser flops before reading it back
      repeat (3) @(posedge clk);
      rdr(REG_STATUS, 32'h1, 32'h1);
      rd(5);
      mode = MODE_X18;
      wb(1'b1, REG_CTRL, 32'h1);
      wr(2, 4'he, 2'h0, pat(80), 4'hd, 2'h0, pat(81));
      rd(2);
      mode = MODE_X8;
      wb(1'b1, REG_CTRL, 32'h2);
      rdr(REG_CTRL, 32'h2, 32'h7);
      wr(3, 4'h0, 2'h2, pat(82), 4'h0, 2'h1, pat(83));
      rd(3);
      // fill the write fifo with drain held, then release it
      mode = MODE_X36;
      wb(1'b1, REG_CTRL, 32'h4);
      for (int i = 0; i < FIFO_D + 2; i++) begin
         u_ctl.kcyc(1'b0, 1'b0, 4'(i), 4'h0, 4'h0, 2'h3, 2'h3, pat(100 + i), pat(200 + i));
         if (i < FIFO_D) mem0[i % 16] = pat(100 + i);
         if (i < FIFO_D) mem1[i % 16] = pat(200 + i);
      end
      nop();
      nop();
      rdr(REG_STATUS, 32'h2, 32'h6);
      rdr(REG_DROP_CNT, 32'h2, 32'hffff);
      wb(1'b1, REG_CTRL, 32'h0);
      for (int n = 0; n < 100 && q[ST_EMPTY_BIT] !== 1'b1; n++) wb(1'b0, REG_STATUS, 32'h0);
      rdr(REG_WR_CNT, 32'h42, 32'hffff);
      rd(15);
      rd(0);
      print_verdict();
   end

   // watchdog, well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
endmodule // test_ddr_sram_b2_command_write_mask
